// ---- common/sfag_params.svh ----
// constants for the sector flash access guard: offsets, fields, resets, codes
`ifndef SFAG_PARAMS_SVH
`define SFAG_PARAMS_SVH
// register byte offsets
`define SFAG_OFS_CTRL 8'h00
`define SFAG_OFS_KEY 8'h04
`define SFAG_OFS_ADDR 8'h08
`define SFAG_OFS_DATA 8'h0c
`define SFAG_OFS_OPT 8'h10
`define SFAG_OFS_STAT 8'h14
// control register fields and reset
`define SFAG_CTRL_RESET 8'h00
`define SFAG_CTRL_PGM 0
`define SFAG_CTRL_SERA 1
`define SFAG_CTRL_BERA 2
`define SFAG_CTRL_BUSY 3
`define SFAG_CTRL_REFUSED 4
`define SFAG_CTRL_UNLOCKED 5
// write guard unlock keys (arbitrary values)
`define SFAG_KEY1 8'h56
`define SFAG_KEY2 8'hae
// array layout: 16 Kbyte array at the top of the 64 Kbyte space
`define SFAG_IDX_W 14
`define SFAG_FLASH_BYTES 16384
`define SFAG_FLASH_BASE 16'hc000
`define SFAG_SEC0_BASE 16'hf000
`define SFAG_SEC1_BASE 16'he000
`define SFAG_TOP_ADDR 16'hffff
`define SFAG_ERASED 8'hff
`define SFAG_BLOCKED 8'h00
// serial link commands
`define SFAG_CMD_PGM 8'h01
`define SFAG_CMD_SERA 8'h02
`define SFAG_CMD_BERA 8'h03
`define SFAG_CMD_READ 8'h04
`endif

// ---- common/sfag_pkg.sv ----
// types shared by the sector flash access guard
package sfag_pkg;
  typedef enum logic [1:0] {
    MODE_APP = 2'b00,
    MODE_BOARD = 2'b01,
    MODE_OFFBOARD = 2'b10
  } sfag_mode_type;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_PGM = 2'b01,
    OP_SERA = 2'b10,
    OP_BERA = 2'b11
  } sfag_op_type;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_ERASE = 1'b1
  } sfag_state_type;
endpackage : sfag_pkg

// ---- rtl/sfag_flash_guard.sv ----
// flash access guard: apb registers, sector protection, erase engine, array
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "sfag_params.svh"
module sfag_flash_guard (
  // system
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode pins
  input wire logic toolDetectPin,
  input wire logic progModeSelectSupply,
  input wire logic offBoardPin,
  // serial programming pins
  input wire logic serialProgClockIn,
  output logic serialProgClockOut,
  output logic serialProgClockOe,
  input wire logic serialProgDataIn,
  output logic serialProgDataOut,
  output logic serialProgDataOe,
  // application use of the link pins
  input wire logic appClockOut,
  input wire logic appClockOe,
  input wire logic appDataOut,
  input wire logic appDataOe
);
  logic [7:0] mem [0:`SFAG_FLASH_BYTES-1];
  logic [2:0] pinSync1, pinSync2;
  sfag_pkg::sfag_mode_type mode;
  sfag_pkg::sfag_state_type state, next_state;
  logic toolOn, sessionOn;
  logic [7:0] rxByte, linkCmd, next_linkCmd;
  logic rxStrobe, txData, txOe, txLoad;
  logic [7:0] txByte;
  logic [1:0] linkIdx, next_linkIdx;
  logic [15:0] linkAddr, next_linkAddr, addrReg, next_addrReg;
  logic [7:0] dataReg, next_dataReg;
  logic lockOpt, next_lockOpt, clearPending, next_clearPending;
  logic unlocked, next_unlocked, keyStage, next_keyStage;
  logic refused, next_refused;
  logic [`SFAG_IDX_W-1:0] eraseIdx, next_eraseIdx, eraseEnd, next_eraseEnd;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_clkOut, next_clkOe, next_datOut, next_datOe;
  logic apbWr, apbGo, linkGo, reqValid, reqOk, pgmGo;
  sfag_pkg::sfag_op_type reqOp;
  logic [15:0] reqAddr;
  logic [7:0] reqData;
  logic [1:0] reqSec;
  logic reqSecValid, reqWritable;
  logic [15:0] secLo, secHi;
  logic memWe;
  logic [`SFAG_IDX_W-1:0] memIdx;
  logic [7:0] memWd;

  //////////////////////////////////////////////////////////////////////////////
  // mode pins pass two flops; the second stage alone feeds logic
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pinSync1 <= 3'b000;
      pinSync2 <= 3'b000;
    end else begin
      pinSync1 <= {offBoardPin, progModeSelectSupply, toolDetectPin};
      pinSync2 <= pinSync1;
    end
  end

  // mode decode: socket first, then tool-selected circuit comm mode
  always_comb begin
    toolOn = pinSync2[0];
    if (pinSync2[2]) begin
      mode = sfag_pkg::MODE_OFFBOARD;
    end else if (pinSync2[1] && toolOn) begin
      mode = sfag_pkg::MODE_BOARD;
    end else begin
      mode = sfag_pkg::MODE_APP;
    end
    sessionOn = (mode == sfag_pkg::MODE_BOARD);
  end

  //////////////////////////////////////////////////////////////////////////////
  sfag_serial_link u_link (
    .clk(clk),
    .resetn(resetn),
    .linkClkPin(serialProgClockIn),
    .linkDataPin(serialProgDataIn),
    .sessionOn(sessionOn),
    .txLoad(txLoad),
    .txByte(txByte),
    .rxByte(rxByte),
    .rxStrobe(rxStrobe),
    .txData(txData),
    .txOe(txOe)
  );

  sfag_sector_decode u_dec (
    .addr(reqAddr),
    .mode(mode),
    .secNum(reqSec),
    .secValid(reqSecValid),
    .secWritable(reqWritable),
    .secLo(secLo),
    .secHi(secHi)
  );

  //////////////////////////////////////////////////////////////////////////////
  // frames, requests, guard, erase engine, apb answers and pin muxing
  always_comb begin
    next_state = state;
    next_linkIdx = linkIdx;
    next_linkCmd = linkCmd;
    next_linkAddr = linkAddr;
    next_addrReg = addrReg;
    next_dataReg = dataReg;
    next_lockOpt = lockOpt;
    next_clearPending = clearPending;
    next_unlocked = unlocked;
    next_keyStage = keyStage;
    next_refused = refused;
    next_eraseIdx = eraseIdx;
    next_eraseEnd = eraseEnd;
    apbWr = psel && penable && pready && pwrite;
    // four-byte link frame: command, address high, address low, data
    linkGo = sessionOn && rxStrobe && linkIdx == 2'd3;
    if (!sessionOn) begin
      next_linkIdx = 2'd0;
    end else if (rxStrobe) begin
      next_linkIdx = 2'(linkIdx + 2'd1);
      if (linkIdx == 2'd0) next_linkCmd = rxByte;
      if (linkIdx == 2'd1) next_linkAddr = {rxByte, linkAddr[7:0]};
      if (linkIdx == 2'd2) next_linkAddr = {linkAddr[15:8], rxByte};
    end
    apbGo = apbWr && paddr == `SFAG_OFS_CTRL && |pwdata[`SFAG_CTRL_BERA:`SFAG_CTRL_PGM];
    // link wins when both ask in the same cycle
    reqOp = sfag_pkg::OP_NONE;
    reqAddr = addrReg;
    reqData = dataReg;
    if (linkGo) begin
      reqAddr = linkAddr;
      reqData = rxByte;
      unique case (linkCmd)
        `SFAG_CMD_PGM: reqOp = sfag_pkg::OP_PGM;
        `SFAG_CMD_SERA: reqOp = sfag_pkg::OP_SERA;
        `SFAG_CMD_BERA: reqOp = sfag_pkg::OP_BERA;
        default: reqOp = sfag_pkg::OP_NONE;
      endcase
    end else if (apbGo) begin
      if (pwdata[`SFAG_CTRL_PGM]) reqOp = sfag_pkg::OP_PGM;
      else if (pwdata[`SFAG_CTRL_SERA]) reqOp = sfag_pkg::OP_SERA;
      else reqOp = sfag_pkg::OP_BERA;
    end
    reqValid = (reqOp != sfag_pkg::OP_NONE);
    reqOk = reqValid && state == sfag_pkg::ST_IDLE && (linkGo || unlocked)
      && (reqOp == sfag_pkg::OP_BERA ? mode != sfag_pkg::MODE_APP : reqWritable);
    pgmGo = reqOk && reqOp == sfag_pkg::OP_PGM;
    // link reads answer with zero bytes while the lock holds
    txLoad = linkGo && linkCmd == `SFAG_CMD_READ;
    txByte = (lockOpt || linkAddr < `SFAG_FLASH_BASE) ? `SFAG_BLOCKED : mem[linkAddr[`SFAG_IDX_W-1:0]];
    if (apbGo && !linkGo) next_unlocked = 1'b0; // one operation per unlock
    memWe = 1'b0;
    memIdx = reqAddr[`SFAG_IDX_W-1:0];
    memWd = reqData;
    unique case (state)
      sfag_pkg::ST_IDLE: begin
        if (pgmGo) begin
          memWe = 1'b1;
        end else if (reqOk && reqOp == sfag_pkg::OP_SERA) begin
          next_eraseIdx = `SFAG_IDX_W'(secLo - `SFAG_FLASH_BASE);
          next_eraseEnd = `SFAG_IDX_W'(secHi - `SFAG_FLASH_BASE);
          next_state = sfag_pkg::ST_ERASE;
        end else if (reqOk) begin
          next_eraseIdx = '0;
          next_eraseEnd = '1;
          next_state = sfag_pkg::ST_ERASE;
        end else if (apbWr && paddr == `SFAG_OFS_OPT && unlocked && mode != sfag_pkg::MODE_APP) begin
          if (pwdata[0]) begin
            next_lockOpt = 1'b1;
          end else if (lockOpt) begin
            next_clearPending = 1'b1;
            next_eraseIdx = '0;
            next_eraseEnd = '1;
            next_state = sfag_pkg::ST_ERASE;
          end
          next_unlocked = 1'b0;
        end
      end
      sfag_pkg::ST_ERASE: begin
        memWe = 1'b1;
        memIdx = eraseIdx;
        memWd = `SFAG_ERASED;
        next_eraseIdx = `SFAG_IDX_W'(eraseIdx + 1'b1);
        if (eraseIdx == eraseEnd) begin
          next_state = sfag_pkg::ST_IDLE;
          if (clearPending) next_lockOpt = 1'b0;
          next_clearPending = 1'b0;
        end
      end
    endcase
    // register side effects
    if (apbWr && paddr == `SFAG_OFS_ADDR) next_addrReg = pwdata[15:0];
    if (apbWr && paddr == `SFAG_OFS_DATA) next_dataReg = pwdata[7:0];
    if (apbWr && paddr == `SFAG_OFS_KEY) begin
      next_keyStage = (pwdata[7:0] == `SFAG_KEY1);
      next_unlocked = keyStage && pwdata[7:0] == `SFAG_KEY2;
    end
    // refused flag: write one clears, a new refusal wins
    if (apbWr && paddr == `SFAG_OFS_CTRL && pwdata[`SFAG_CTRL_REFUSED]) next_refused = 1'b0;
    if ((reqValid && !reqOk) || (txLoad && lockOpt)) next_refused = 1'b1;
    // apb answer prepared in the setup cycle, shown in the access cycle
    next_pready = psel && !penable;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        `SFAG_OFS_CTRL: next_prdata = {26'h0, unlocked, refused, state == sfag_pkg::ST_ERASE, 3'b000};
        `SFAG_OFS_KEY: next_prdata = 32'h0000_0000;
        `SFAG_OFS_ADDR: next_prdata = {16'h0000, addrReg};
        `SFAG_OFS_DATA: next_prdata = {24'h0, mem[addrReg[`SFAG_IDX_W-1:0]]};
        `SFAG_OFS_OPT: next_prdata = {31'h0, lockOpt};
        `SFAG_OFS_STAT: next_prdata = {27'h0, clearPending, state == sfag_pkg::ST_ERASE, toolOn, mode};
        default: next_pslverr = 1'b1;
      endcase
    end
    // link pins leave the application once the tool is attached
    next_clkOut = toolOn ? 1'b0 : appClockOut;
    next_clkOe = toolOn ? 1'b0 : appClockOe;
    next_datOut = toolOn ? txData : appDataOut;
    next_datOe = toolOn ? txOe : appDataOe;
  end

  // register the control state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= sfag_pkg::ST_IDLE;
      linkIdx <= 2'd0;
      linkCmd <= 8'h00;
      linkAddr <= 16'h0000;
      addrReg <= 16'h0000;
      dataReg <= 8'h00;
      lockOpt <= 1'b0;
      clearPending <= 1'b0;
      unlocked <= 1'b0;
      keyStage <= 1'b0;
      refused <= 1'b0;
      eraseIdx <= '0;
      eraseEnd <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      serialProgClockOut <= 1'b0;
      serialProgClockOe <= 1'b0;
      serialProgDataOut <= 1'b0;
      serialProgDataOe <= 1'b0;
    end else begin
      state <= next_state;
      linkIdx <= next_linkIdx;
      linkCmd <= next_linkCmd;
      linkAddr <= next_linkAddr;
      addrReg <= next_addrReg;
      dataReg <= next_dataReg;
      lockOpt <= next_lockOpt;
      clearPending <= next_clearPending;
      unlocked <= next_unlocked;
      keyStage <= next_keyStage;
      refused <= next_refused;
      eraseIdx <= next_eraseIdx;
      eraseEnd <= next_eraseEnd;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      serialProgClockOut <= next_clkOut;
      serialProgClockOe <= next_clkOe;
      serialProgDataOut <= next_datOut;
      serialProgDataOe <= next_datOe;
    end
  end

  // array write port, no reset on the storage
  always_ff @(posedge clk) begin
    if (memWe) mem[memIdx] <= memWd;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_ctrl_reset;
    @(posedge clk) !resetn |=> !refused && !unlocked && state == sfag_pkg::ST_IDLE;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control state not zero after reset");
  property p_sec0_app;
    @(posedge clk) disable iff (!resetn) memWe && mode == sfag_pkg::MODE_APP |-> memIdx[13:12] != 2'b11;
  endproperty
  a_sec0_app: assert property (p_sec0_app) else $error("sector 0 written in app mode");
  property p_refuse_flag;
    @(posedge clk) disable iff (!resetn) reqValid && !reqOk |=> refused;
  endproperty
  a_refuse_flag: assert property (p_refuse_flag) else $error("refused request not flagged");
  property p_guard;
    @(posedge clk) disable iff (!resetn) apbGo && !linkGo && !unlocked && state == sfag_pkg::ST_IDLE
      |-> !memWe ##1 state == sfag_pkg::ST_IDLE;
  endproperty
  a_guard: assert property (p_guard) else $error("apb operation ran while locked");
  property p_byte_prog;
    @(posedge clk) disable iff (!resetn) pgmGo |-> memWe && memWd == reqData && state == sfag_pkg::ST_IDLE;
  endproperty
  a_byte_prog: assert property (p_byte_prog) else $error("program did not write one byte");
  property p_erase_stays;
    @(posedge clk) disable iff (!resetn) state == sfag_pkg::ST_ERASE && eraseIdx != eraseEnd
      |=> state == sfag_pkg::ST_ERASE && eraseIdx == $past(eraseIdx) + 1'b1;
  endproperty
  a_erase_stays: assert property (p_erase_stays) else $error("erase walk broke off");
  property p_lock_clear;
    @(posedge clk) disable iff (!resetn) $fell(lockOpt) |-> $past(clearPending) && $past(eraseIdx) == '1;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock cleared without full erase");
  property p_read_block;
    @(posedge clk) disable iff (!resetn) txLoad && lockOpt |-> txByte == `SFAG_BLOCKED;
  endproperty
  a_read_block: assert property (p_read_block) else $error("locked array read out");
  property p_pin_release;
    @(posedge clk) disable iff (!resetn) toolOn |=> !serialProgClockOe && serialProgDataOe == $past(txOe);
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("link pins still in app use");
  property p_vector_sector;
    @(posedge clk) disable iff (!resetn) reqAddr >= `SFAG_SEC0_BASE |-> reqSec == 2'd0;
  endproperty
  a_vector_sector: assert property (p_vector_sector) else $error("top range not sector 0");
  c_sector_erase: cover property (@(posedge clk) disable iff (!resetn) reqOk && reqOp == sfag_pkg::OP_SERA);
  c_lock_removed: cover property (@(posedge clk) disable iff (!resetn) $fell(lockOpt));
  c_link_prog: cover property (@(posedge clk) disable iff (!resetn) pgmGo && linkGo);
endmodule : sfag_flash_guard

// ---- rtl/sfag_sector_decode.sv ----
// address to sector decode with availability and mode protection
`timescale 1ns/10ps
`include "sfag_params.svh"
module sfag_sector_decode (
  // request
  input wire logic [15:0] addr,
  input wire sfag_pkg::sfag_mode_type mode,
  // result
  output logic [1:0] secNum,
  output logic secValid,
  output logic secWritable,
  output logic [15:0] secLo,
  output logic [15:0] secHi
);
  // sector 0 on top, sector 1 below it, sector 2 takes the rest
  always_comb begin
    secValid = (addr >= `SFAG_FLASH_BASE);
    if (addr >= `SFAG_SEC0_BASE) begin
      secNum = 2'd0;
      secLo = `SFAG_SEC0_BASE;
      secHi = `SFAG_TOP_ADDR;
    end else if (addr >= `SFAG_SEC1_BASE) begin
      secNum = 2'd1;
      secLo = `SFAG_SEC1_BASE;
      secHi = 16'(`SFAG_SEC0_BASE - 16'h0001);
    end else begin
      secNum = 2'd2;
      secLo = `SFAG_FLASH_BASE;
      secHi = 16'(`SFAG_SEC1_BASE - 16'h0001);
    end
    // sector 0 stays closed while the application programs itself
    secWritable = secValid && !(mode == sfag_pkg::MODE_APP && secNum == 2'd0);
  end
endmodule : sfag_sector_decode

// ---- rtl/sfag_serial_link.sv ----
// serial programming link: pin sync, byte receive, byte transmit
`timescale 1ns/10ps
module sfag_serial_link (
  // system
  input wire logic clk,
  input wire logic resetn,
  // raw link pins
  input wire logic linkClkPin,
  input wire logic linkDataPin,
  // control
  input wire logic sessionOn,
  input wire logic txLoad,
  input wire logic [7:0] txByte,
  // results
  output logic [7:0] rxByte,
  output logic rxStrobe,
  output logic txData,
  output logic txOe
);
  logic [1:0] clkSync, dataSync;
  logic clkLast;
  logic [7:0] rxShift, txShift;
  logic [2:0] rxCnt, txLeft;
  logic [1:0] next_clkSync, next_dataSync;
  logic next_clkLast, next_rxStrobe, next_txData, next_txOe;
  logic [7:0] next_rxShift, next_txShift, next_rxByte;
  logic [2:0] next_rxCnt, next_txLeft;
  logic rise, fall;

  // two-stage sync, edge find, msb-first shift in on rise, out on fall
  always_comb begin
    next_clkSync = {clkSync[0], linkClkPin};
    next_dataSync = {dataSync[0], linkDataPin};
    next_clkLast = clkSync[1];
    rise = clkSync[1] && !clkLast;
    fall = !clkSync[1] && clkLast;
    next_rxShift = rxShift;
    next_rxCnt = rxCnt;
    next_rxByte = rxByte;
    next_rxStrobe = 1'b0;
    next_txShift = txShift;
    next_txLeft = txLeft;
    next_txData = txData;
    next_txOe = txOe;
    if (!sessionOn) begin
      next_rxCnt = 3'd0;
      next_txOe = 1'b0;
    end else if (txLoad) begin
      next_txData = txByte[7];
      next_txShift = {txByte[6:0], 1'b0};
      next_txLeft = 3'd7;
      next_txOe = 1'b1;
    end else if (txOe) begin
      if (fall) begin
        if (txLeft != 3'd0) begin
          next_txData = txShift[7];
          next_txShift = {txShift[6:0], 1'b0};
          next_txLeft = 3'(txLeft - 3'd1);
        end else begin
          next_txOe = 1'b0;
        end
      end
    end else if (rise) begin
      next_rxShift = {rxShift[6:0], dataSync[1]};
      next_rxCnt = 3'(rxCnt + 3'd1);
      if (rxCnt == 3'd7) begin
        next_rxByte = {rxShift[6:0], dataSync[1]};
        next_rxStrobe = 1'b1;
      end
    end
  end

  // register the link state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clkSync <= 2'b00;
      dataSync <= 2'b00;
      clkLast <= 1'b0;
      rxShift <= 8'h00;
      rxCnt <= 3'd0;
      rxByte <= 8'h00;
      rxStrobe <= 1'b0;
      txShift <= 8'h00;
      txLeft <= 3'd0;
      txData <= 1'b0;
      txOe <= 1'b0;
    end else begin
      clkSync <= next_clkSync;
      dataSync <= next_dataSync;
      clkLast <= next_clkLast;
      rxShift <= next_rxShift;
      rxCnt <= next_rxCnt;
      rxByte <= next_rxByte;
      rxStrobe <= next_rxStrobe;
      txShift <= next_txShift;
      txLeft <= next_txLeft;
      txData <= next_txData;
      txOe <= next_txOe;
    end
  end
endmodule : sfag_serial_link

// ---- verif/sfag_prog_tool.sv ----
// behavioural programming tool driving the serial link and mode pins
`timescale 1ns/10ps
module sfag_prog_tool (
  // link and mode pins
  output logic linkClk,
  output logic linkData,
  output logic attached,
  output logic modeSel,
  // resolved data wire
  input wire logic dataWire
);
  initial begin
    linkClk = 1'b0;
    linkData = 1'b0;
    attached = 1'b0;
    modeSel = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // attach and select circuit comm mode before any frame
  task automatic attach(input logic on);
    attached = on;
    modeSel = on;
    #400;
  endtask : attach
  // one 80 ns link clock pulse, data set while clock low
  task automatic pulse(input logic bitVal);
    linkData = bitVal;
    #40 linkClk = 1'b1;
    #40 linkClk = 1'b0;
  endtask : pulse
  // send four bytes msb first, then release the data line
  task automatic send(input logic [7:0] cmd, input logic [15:0] ad, input logic [7:0] dt);
    logic [31:0] w;
    w = {cmd, ad, dt};
    #1.3;
    for (int i = 31; i >= 0; i--) pulse(w[i]);
    linkData = ~linkData; // released: inverse of last bit
  endtask : send
  task automatic frame(input logic [7:0] cmd, input logic [15:0] ad, input logic [7:0] dt);
    send(cmd, ad, dt);
    #200;
  endtask : frame
  // read frame: msb stands before the last frame fall, seven more pulses bring the rest
  task automatic rdframe(input logic [15:0] ad, output logic [7:0] q);
    logic [31:0] w;
    w = {8'h04, ad, 8'h00};
    #1.3;
    for (int i = 31; i > 0; i--) pulse(w[i]);
    linkData = w[0];
    #40 linkClk = 1'b1;
    #40 q[7] = dataWire;
    linkClk = 1'b0;
    for (int i = 6; i >= 0; i--) begin
      #40 linkClk = 1'b1;
      q[i] = dataWire;
      #40 linkClk = 1'b0;
    end
    linkData = ~linkData; // released: inverse of last bit
    #200;
  endtask : rdframe
endmodule : sfag_prog_tool

// ---- verif/tb_sfag_flash_guard.sv ----
// self-checking testbench for the flash access guard
`timescale 1ns/10ps
`include "sfag_params.svh"
module tb_sfag_flash_guard;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, offBoardPin;
  logic [7:0] paddr, a, d, b, q;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] app, snap;
  logic toolDetect, modeSel, linkClk, toolData, dataWire, clkOut, clkOe, dataOut, dataOe;
  logic [64:0] expq[$];
  logic [64:0] mon;
  int error_cnt = 0;
  int checked = 0;
  sfag_flash_guard i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .toolDetectPin(toolDetect), .progModeSelectSupply(modeSel), .offBoardPin(offBoardPin),
    .serialProgClockIn(linkClk), .serialProgClockOut(clkOut), .serialProgClockOe(clkOe),
    .serialProgDataIn(dataWire), .serialProgDataOut(dataOut), .serialProgDataOe(dataOe),
    .appClockOut(app[0]), .appClockOe(app[1]), .appDataOut(app[2]), .appDataOe(app[3]));
  sfag_prog_tool i_tool (.linkClk(linkClk), .linkData(toolData), .attached(toolDetect), .modeSel(modeSel),
    .dataWire(dataWire));
  assign dataWire = dataOe ? dataOut : toolData;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) app <= 4'($urandom);
  ////////////////////////////////////////////////////////////////////////////////
  // compare, verdict and hang handling
  task chk(input logic [31:0] got, input logic [31:0] ex);
    checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask : chk
  task give_verdict;
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task hang;
    error_cnt++;
    give_verdict();
  endtask : hang
  // read monitor takes the oldest note at each completed read
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      mon = expq.pop_front();
      chk({31'h0, pslverr}, {31'h0, mon[64]});
      chk(prdata & mon[63:32], mon[31:0]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // apb master: setup, access until pready, then release
  task apb(input logic [7:0] ad, input logic w, input logic [31:0] wd, input logic [31:0] m,
           input logic [31:0] ex, input logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= wd;
    if (!w) expq.push_back({er, m, ex & m});
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) hang();
  endtask : apb
  task wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(ad, 1'b1, wd, 32'h0, 32'h0, 1'b0);
  endtask : wr
  task rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] ex);
    apb(ad, 1'b0, 32'h0, m, ex, 1'b0);
  endtask : rd
  task unlock;
    wr(`SFAG_OFS_KEY, {24'h0, `SFAG_KEY1});
    wr(`SFAG_OFS_KEY, {24'h0, `SFAG_KEY2});
  endtask : unlock
  // poll busy with a bounded count
  task idle;
    int n;
    n = 0;
    do begin
      rd(`SFAG_OFS_STAT, 32'h0, 32'h0);
      n++;
    end while (r[3] !== 1'b0 && n < 8000);
    if (n >= 8000) hang();
  endtask : idle
  task op(input logic [15:0] ad, input logic [7:0] dt, input logic [2:0] c, input logic key);
    wr(`SFAG_OFS_ADDR, {16'h0, ad});
    wr(`SFAG_OFS_DATA, {24'h0, dt});
    if (key) unlock();
    wr(`SFAG_OFS_CTRL, {29'h0, c});
    idle();
  endtask : op
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    offBoardPin = 1'b0;
    void'($urandom(32'hf46e0ecf));
    a = 8'($urandom);
    d = 8'($urandom);
    b = 8'($urandom);
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(`SFAG_OFS_CTRL, 32'hff, 32'h0);
    apb(8'h18, 1'b0, 32'h0, 32'hffffffff, 32'h0, 1'b1);
    rd(`SFAG_OFS_STAT, 32'h7, 32'h0);
    op(16'hc000, a, 3'h2, 1'b1);
    op(16'hc000, a, 3'h1, 1'b1);
    op(16'hefff, d, 3'h2, 1'b1);
    op(16'hefff, d, 3'h1, 1'b1);
    rd(`SFAG_OFS_DATA, 32'hff, {24'h0, d});
    op(16'hf000, 8'h00, 3'h2, 1'b1);
    rd(`SFAG_OFS_CTRL, 32'h10, 32'h10);
    wr(`SFAG_OFS_CTRL, 32'h10);
    op(16'hc000, 8'h00, 3'h4, 1'b1);
    rd(`SFAG_OFS_DATA, 32'hff, {24'h0, a});
    op(16'hefff, 8'h00, 3'h1, 1'b0);
    rd(`SFAG_OFS_DATA, 32'hff, {24'h0, d});
    // without the tool the link pins follow the application one cycle late
    repeat (4) begin
      @(posedge clk);
      snap = app;
      #1 chk({28'h0, dataOe, dataOut, clkOe, clkOut}, {28'h0, snap});
    end
    i_tool.attach(1'b1);
    rd(`SFAG_OFS_STAT, 32'h7, 32'h5);
    chk({30'h0, clkOe, clkOut}, 32'h0);
    i_tool.frame(`SFAG_CMD_SERA, 16'hffff, 8'h00);
    idle();
    i_tool.frame(`SFAG_CMD_PGM, 16'hf000, b);
    i_tool.rdframe(16'hf000, q);
    chk({24'h0, q}, {24'h0, b});
    i_tool.rdframe(16'hefff, q);
    chk({24'h0, q}, {24'h0, d});
    unlock();
    wr(`SFAG_OFS_OPT, 32'h1);
    rd(`SFAG_OFS_OPT, 32'h1, 32'h1);
    i_tool.rdframe(16'hefff, q);
    chk({24'h0, q}, {24'h0, `SFAG_BLOCKED});
    unlock();
    wr(`SFAG_OFS_OPT, 32'h0);
    idle();
    rd(`SFAG_OFS_OPT, 32'h1, 32'h0);
    i_tool.rdframe(16'hc000, q);
    chk({24'h0, q}, {24'h0, `SFAG_ERASED});
    give_verdict();
  end
endmodule : tb_sfag_flash_guard
